// *** reset_cause_pkg.sv ***
package reset_cause_pkg;

    // ----------------------------------------------------------------
    // register addresses on the cpu address bus
    // ----------------------------------------------------------------
    localparam logic [15:0] STATUS_ADDR = 16'h1800;
    localparam logic [15:0] FORCE_ADDR  = 16'h1801;

    // ----------------------------------------------------------------
    // illegal address gaps
    // ----------------------------------------------------------------
    localparam logic [15:0] GAP_A_LO = 16'h0470;
    localparam logic [15:0] GAP_A_HI = 16'h17FF;
    localparam logic [15:0] GAP_B_LO = 16'h1860;
    localparam logic [15:0] GAP_B_HI = 16'hBFFF;

    // ----------------------------------------------------------------
    // status flag positions and values
    // ----------------------------------------------------------------
    localparam int unsigned FLAG_POR    = 7;
    localparam int unsigned FLAG_PIN    = 6;
    localparam int unsigned FLAG_WDOG   = 5;
    localparam int unsigned FLAG_ILLEGAL_OPCODE_FLAG   = 4;
    localparam int unsigned FLAG_ILLEGAL_ADDRESS_FLAG   = 3;
    localparam int unsigned FLAG_CLKGEN = 2;
    localparam int unsigned FLAG_LOWV   = 1;
    localparam int unsigned FORCE_BIT   = 0;

    localparam logic [7:0] POR_VALUE = 8'h82;
    localparam logic [7:0] READ_MASK = 8'hFE;
    localparam logic [7:0] ZERO_BYTE = 8'h00;

    // ----------------------------------------------------------------
    // reset pulse timing
    // ----------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_PS = 5000;
    localparam int unsigned HOLD_TIME_NS  = 50;
    localparam logic [3:0]  HOLD_CYCLES   =
        4'((HOLD_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
    localparam logic [3:0]  COUNT_DONE    = 4'h1;

    typedef enum logic [1:0] {
        ST_RUN  = 2'h0,
        ST_HOLD = 2'h1,
        ST_WAIT = 2'h3
    } seq_state_t;

endpackage

// *** reset_cause_unit.sv ***
`timescale 1ns/1ps
// How it works
// - read-only 8-bit status with seven reset cause flags
// - forced debug reset leaves every status flag clear
// - any write to status address clears watchdog, flags untouched
// - power-on sets bit 7 and bit 1, others clear
// - low-voltage reset keeps bit 7, sets bit 1, clears rest
// - other resets flag each active source except force, clear power-on and low-voltage
// - external pin low sets bit 6
// - watchdog timeout sets bit 5; blocked while watchdog disabled
// - illegal opcode sets bit 4; stop or debug entry illegal when disabled
// - access in gap after ram raises illegal address reset, bit 3
// - access in gap before flash raises illegal address reset
// - unused register locations are not illegal addresses
// - clock generator request sets bit 2
// - low supply with both enables set resets and sets bit 1
// - user program writes to force register are ignored
// - force register always reads zero
// - debug write of one to force bit triggers full reset
// - stop with stop mode disabled gives illegal opcode reset
// - enabled watchdog timeout forces a reset
module reset_cause_unit (
    input  wire logic        REF_CLK_I,
    input  wire logic        RESET_I,
    input  wire logic [15:0] BUS_ADDR_I,
    input  wire logic        BUS_VALID_I,
    input  wire logic        BUS_WRITE_I,
    input  wire logic [7:0]  BUS_WDATA_I,
    input  wire logic        BUS_FROM_DEBUG_I,
    input  wire logic        OPCODE_FETCH_I,
    input  wire logic        OPCODE_UNDEFINED_I,
    input  wire logic        OPCODE_IS_STOP_I,
    input  wire logic        OPCODE_IS_DEBUG_I,
    input  wire logic        STOP_MODE_ENABLE_I,
    input  wire logic        DEBUG_MODE_ENABLE_I,
    input  wire logic        WATCHDOG_ENABLE_I,
    input  wire logic        WATCHDOG_TIMEOUT_I,
    input  wire logic        EXT_RESET_N_I,
    input  wire logic        CLKGEN_RESET_REQ_I,
    input  wire logic        LOW_VOLTAGE_TRIP_I,
    input  wire logic        LOW_VOLTAGE_RESET_ENABLE_I,
    input  wire logic        LOW_VOLTAGE_STOP_ENABLE_I,
    output logic      [7:0]  BUS_RDATA_O,
    output logic             WATCHDOG_CLEAR_O,
    output logic             MCU_RESET_O
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    reset_cause_pkg::seq_state_t state;
    logic [3:0]                  hold_count;
    logic [7:0]                  status;
    logic [7:0]                  next_status;

    logic status_hit;
    logic force_hit;
    logic pin_hit;
    logic wdog_hit;
    logic illegal_opcode_flag_hit;
    logic illegal_address_flag_hit;
    logic clk_hit;
    logic lowv_hit;
    logic any_hit;
    logic in_run;

    // ----------------------------------------------------------------
    // reset source detection
    // ----------------------------------------------------------------

    // address decode for the two registers
    always_comb begin
        status_hit = BUS_VALID_I && (BUS_ADDR_I == reset_cause_pkg::STATUS_ADDR);
        force_hit  = BUS_VALID_I && BUS_WRITE_I && BUS_FROM_DEBUG_I
                     && (BUS_ADDR_I == reset_cause_pkg::FORCE_ADDR)
                     && BUS_WDATA_I[reset_cause_pkg::FORCE_BIT];
    end

    // only the two gaps count; register areas stay legal
    always_comb begin
        illegal_address_flag_hit = BUS_VALID_I && (
            ((BUS_ADDR_I >= reset_cause_pkg::GAP_A_LO)
             && (BUS_ADDR_I <= reset_cause_pkg::GAP_A_HI))
            || ((BUS_ADDR_I >= reset_cause_pkg::GAP_B_LO)
             && (BUS_ADDR_I <= reset_cause_pkg::GAP_B_HI)));
    end

    // opcode, watchdog, pin, clock and supply sources
    always_comb begin
        illegal_opcode_flag_hit = OPCODE_FETCH_I && (OPCODE_UNDEFINED_I
                   || (OPCODE_IS_STOP_I && !STOP_MODE_ENABLE_I)
                   || (OPCODE_IS_DEBUG_I && !DEBUG_MODE_ENABLE_I));
        wdog_hit = WATCHDOG_TIMEOUT_I && WATCHDOG_ENABLE_I;
        pin_hit  = !EXT_RESET_N_I;
        clk_hit  = CLKGEN_RESET_REQ_I;
        lowv_hit = LOW_VOLTAGE_TRIP_I && LOW_VOLTAGE_RESET_ENABLE_I
                   && LOW_VOLTAGE_STOP_ENABLE_I;
        any_hit  = force_hit || illegal_opcode_flag_hit || wdog_hit || pin_hit
                   || clk_hit || lowv_hit || illegal_address_flag_hit;
        in_run   = (state == reset_cause_pkg::ST_RUN);
    end

    // ----------------------------------------------------------------
    // cause capture
    // ----------------------------------------------------------------

    // low voltage dominates; the force source adds no flag of its own
    always_comb begin
        next_status = reset_cause_pkg::ZERO_BYTE;
        if (lowv_hit) begin
            next_status[reset_cause_pkg::FLAG_POR]  = status[reset_cause_pkg::FLAG_POR];
            next_status[reset_cause_pkg::FLAG_LOWV] = 1'b1;
        end else begin
            next_status[reset_cause_pkg::FLAG_PIN]    = pin_hit;
            next_status[reset_cause_pkg::FLAG_WDOG]   = wdog_hit;
            next_status[reset_cause_pkg::FLAG_ILLEGAL_OPCODE_FLAG]   = illegal_opcode_flag_hit;
            next_status[reset_cause_pkg::FLAG_ILLEGAL_ADDRESS_FLAG]   = illegal_address_flag_hit;
            next_status[reset_cause_pkg::FLAG_CLKGEN] = clk_hit;
        end
    end

    // only power-on loads the fixed pattern; other resets load the captured causes; bus data never lands here
    always_ff @(posedge REF_CLK_I) begin
        if (RESET_I) begin
            status <= reset_cause_pkg::POR_VALUE;
        end else if (in_run && any_hit) begin
            status <= next_status;
        end
    end

    // ----------------------------------------------------------------
    // reset sequencer
    // ----------------------------------------------------------------

    // events during an active reset are dropped: the cpu is halted anyway
    always_ff @(posedge REF_CLK_I) begin
        if (RESET_I) begin
            state       <= reset_cause_pkg::ST_HOLD;
            hold_count  <= reset_cause_pkg::HOLD_CYCLES;
            MCU_RESET_O <= 1'b1;
        end else begin
            case (state)
                reset_cause_pkg::ST_RUN: begin
                    if (any_hit) begin
                        state       <= reset_cause_pkg::ST_HOLD;
                        hold_count  <= reset_cause_pkg::HOLD_CYCLES;
                        MCU_RESET_O <= 1'b1;
                    end
                end
                reset_cause_pkg::ST_HOLD: begin
                    hold_count <= hold_count - 4'h1;
                    if (hold_count == reset_cause_pkg::COUNT_DONE) begin
                        state <= reset_cause_pkg::ST_WAIT;
                    end
                end
                reset_cause_pkg::ST_WAIT: begin
                    // level sources keep the part in reset until they drop
                    if (!pin_hit && !lowv_hit) begin
                        state       <= reset_cause_pkg::ST_RUN;
                        MCU_RESET_O <= 1'b0;
                    end
                end
                default: begin
                    state       <= reset_cause_pkg::ST_HOLD;
                    hold_count  <= reset_cause_pkg::HOLD_CYCLES;
                    MCU_RESET_O <= 1'b1;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // bus side effects
    // ----------------------------------------------------------------

    // one-cycle watchdog service pulse, from either source
    always_ff @(posedge REF_CLK_I) begin
        if (RESET_I) begin
            WATCHDOG_CLEAR_O <= 1'b0;
        end else begin
            WATCHDOG_CLEAR_O <= status_hit && BUS_WRITE_I;
        end
    end

    // registered read data; force register and unmapped read zero
    always_ff @(posedge REF_CLK_I) begin
        if (RESET_I) begin
            BUS_RDATA_O <= reset_cause_pkg::ZERO_BYTE;
        end else if (status_hit && !BUS_WRITE_I) begin
            BUS_RDATA_O <= status & reset_cause_pkg::READ_MASK;
        end else begin
            BUS_RDATA_O <= reset_cause_pkg::ZERO_BYTE;
        end
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------

    a_por_pattern: assert property (@(posedge REF_CLK_I)
        $fell(RESET_I) |-> status == reset_cause_pkg::POR_VALUE)
        else $error("power-on pattern wrong");

    a_status_readback: assert property (@(posedge REF_CLK_I)
        disable iff (RESET_I)
        status_hit && !BUS_WRITE_I |=> BUS_RDATA_O == (status & reset_cause_pkg::READ_MASK)
            && !BUS_RDATA_O[0])
        else $error("status read wrong");

    a_force_reads_zero: assert property (@(posedge REF_CLK_I)
        disable iff (RESET_I)
        BUS_VALID_I && !BUS_WRITE_I && BUS_ADDR_I == reset_cause_pkg::FORCE_ADDR
        |=> BUS_RDATA_O == reset_cause_pkg::ZERO_BYTE)
        else $error("force register read not zero");

    a_wdog_clear_write: assert property (@(posedge REF_CLK_I)
        disable iff (RESET_I)
        status_hit && BUS_WRITE_I && !any_hit |=> WATCHDOG_CLEAR_O && $stable(status))
        else $error("status write misbehaved");

    a_user_force_ignored: assert property (@(posedge REF_CLK_I)
        disable iff (RESET_I)
        in_run && !any_hit && BUS_WRITE_I && !BUS_FROM_DEBUG_I
        |=> !MCU_RESET_O)
        else $error("user write caused reset");

    a_debug_force_reset: assert property (@(posedge REF_CLK_I)
        disable iff (RESET_I)
        in_run && force_hit |=> MCU_RESET_O [*8])
        else $error("force reset too short");

    a_force_flags_clear: assert property (@(posedge REF_CLK_I)
        disable iff (RESET_I)
        in_run && force_hit && !pin_hit && !wdog_hit && !illegal_opcode_flag_hit && !clk_hit
        && !lowv_hit && !illegal_address_flag_hit |=> status == reset_cause_pkg::ZERO_BYTE)
        else $error("forced reset left flags");

    a_lowv_pattern: assert property (@(posedge REF_CLK_I)
        disable iff (RESET_I)
        in_run && lowv_hit |=> status[reset_cause_pkg::FLAG_LOWV]
            && status[reset_cause_pkg::FLAG_POR] == $past(status[reset_cause_pkg::FLAG_POR])
            && status[6:2] == 5'h00)
        else $error("low voltage pattern wrong");

    a_wdog_blocked: assert property (@(posedge REF_CLK_I)
        disable iff (RESET_I)
        in_run && WATCHDOG_TIMEOUT_I && !WATCHDOG_ENABLE_I && !any_hit |=> !MCU_RESET_O)
        else $error("disabled watchdog reset");

    a_illegal_addr: assert property (@(posedge REF_CLK_I)
        disable iff (RESET_I)
        in_run && illegal_address_flag_hit && !lowv_hit |=> status[reset_cause_pkg::FLAG_ILLEGAL_ADDRESS_FLAG] && MCU_RESET_O)
        else $error("illegal address missed");

    a_stop_illegal: assert property (@(posedge REF_CLK_I)
        disable iff (RESET_I)
        in_run && OPCODE_FETCH_I && OPCODE_IS_STOP_I && !STOP_MODE_ENABLE_I && !lowv_hit
        |=> status[reset_cause_pkg::FLAG_ILLEGAL_OPCODE_FLAG] && !status[reset_cause_pkg::FLAG_POR])
        else $error("stop not treated illegal");

    a_pin_flag: assert property (@(posedge REF_CLK_I)
        disable iff (RESET_I)
        in_run && pin_hit && !lowv_hit |=> status[reset_cause_pkg::FLAG_PIN]
            && !status[reset_cause_pkg::FLAG_LOWV])
        else $error("pin flag missed");

    c_force_reset: cover property (@(posedge REF_CLK_I) in_run && force_hit);
    c_lowv_reset: cover property (@(posedge REF_CLK_I) in_run && lowv_hit);
    c_wdog_service: cover property (@(posedge REF_CLK_I) WATCHDOG_CLEAR_O);
    c_release: cover property (@(posedge REF_CLK_I) $fell(MCU_RESET_O));

endmodule

// *** debug_host_model.sv ***
`timescale 1ns/1ps
module debug_host_model (
    output logic        valid_o,
    output logic [15:0] addr_o,
    output logic [7:0]  data_o
);
    // ----------------------------------------------------------------
    // serial byte write, seen as one debug-marked bus cycle
    // ----------------------------------------------------------------
    // caller holds the command from one falling edge to the next
    task automatic send(input logic [15:0] a, input logic [7:0] d);
        addr_o  = a;
        data_o  = d;
        valid_o = 1'b1;
    endtask

    // released lines flip so a stale byte never looks like a live write
    task automatic idle();
        valid_o = 1'b0;
        addr_o  = ~addr_o;
        data_o  = ~data_o;
    endtask

    // quiet host until the first command
    initial begin
        valid_o = 1'b0;
        addr_o  = 16'h0000;
        data_o  = 8'h00;
    end
endmodule

// *** tb.sv ***
`timescale 1ns/1ps
module tb;
    // ----------------------------------------------------------------
    // stimulus, observation and bookkeeping
    // ----------------------------------------------------------------
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [15:0] addr = 16'h0000;
    logic        valid, wr_en, fetch, undef, is_stop, is_dbg, stop_en, dbg_en;
    logic        wd_en, wd_to, ext_n, clkgen, lv_trip, lv_stop, d_valid;
    logic [7:0]  wdata, d_data, rdata, rnd;
    logic [15:0] d_addr;
    logic        wd_clr, mcu_rst;
    logic        rd_mark = 1'b0;
    logic        rd_seen = 1'b0;
    logic [7:0]  exp_q[$];
    int          seed = 76361;
    int          n_errors = 0;
    int          tests_run = 0;
    // bit 8 = reset expected, low byte = status afterwards
    logic [8:0]  expt [22] = '{9'h140, 9'h120, 9'h000, 9'h110, 9'h110, 9'h000,
        9'h110, 9'h000, 9'h108, 9'h108, 9'h108, 9'h108, 9'h000, 9'h000, 9'h000,
        9'h104, 9'h100, 9'h000, 9'h000, 9'h102, 9'h000, 9'h144};
    // gap edges, then legal neighbours and an unused register slot
    logic [15:0] acc [7] = '{16'h0470, 16'h17FF, 16'h1860, 16'hBFFF, 16'h046F,
        16'hC000, 16'h1802};

    // ----------------------------------------------------------------
    // design, far-side host and clock
    // ----------------------------------------------------------------
    debug_host_model host (.valid_o(d_valid), .addr_o(d_addr), .data_o(d_data));

    reset_cause_unit uut (
        .REF_CLK_I                  (clk),
        .RESET_I                    (rst),
        .BUS_ADDR_I                 (d_valid ? d_addr : addr),
        .BUS_VALID_I                (valid | d_valid),
        .BUS_WRITE_I                (wr_en | d_valid),
        .BUS_WDATA_I                (d_valid ? d_data : wdata),
        .BUS_FROM_DEBUG_I           (d_valid),
        .OPCODE_FETCH_I             (fetch),
        .OPCODE_UNDEFINED_I         (undef),
        .OPCODE_IS_STOP_I           (is_stop),
        .OPCODE_IS_DEBUG_I          (is_dbg),
        .STOP_MODE_ENABLE_I         (stop_en),
        .DEBUG_MODE_ENABLE_I        (dbg_en),
        .WATCHDOG_ENABLE_I          (wd_en),
        .WATCHDOG_TIMEOUT_I         (wd_to),
        .EXT_RESET_N_I              (ext_n),
        .CLKGEN_RESET_REQ_I         (clkgen),
        .LOW_VOLTAGE_TRIP_I         (lv_trip),
        .LOW_VOLTAGE_RESET_ENABLE_I (1'b1),
        .LOW_VOLTAGE_STOP_ENABLE_I  (lv_stop),
        .BUS_RDATA_O                (rdata),
        .WATCHDOG_CLEAR_O           (wd_clr),
        .MCU_RESET_O                (mcu_rst)
    );

    always #2.5 clk = ~clk;

    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // drive one source case k; any k outside the table idles everything
    task automatic apply(input int k);
        rnd     = 8'($random(seed));
        ext_n   = !(k == 0 || k == 21);
        clkgen  = (k == 15 || k == 21);
        wd_en   = (k == 1);
        wd_to   = (k == 1 || k == 2);
        fetch   = (k >= 3 && k <= 7);
        undef   = (k == 3);
        is_stop = (k == 4 || k == 5);
        stop_en = (k == 5);
        is_dbg  = (k == 6 || k == 7);
        dbg_en  = (k == 7);
        lv_trip = (k == 19 || k == 20);
        lv_stop = (k == 19);
        valid   = (k >= 8 && k <= 14) || k == 17;
        wr_en   = (k == 17) ? 1'b1 : rnd[7];
        wdata   = (k == 17) ? 8'h01 : rnd;
        addr    = (k == 17) ? 16'h1801 : (valid ? acc[k - 8] : ~addr);
        if (k == 16 || k == 18) begin
            host.send(16'h1801, (k == 16) ? (rnd | 8'h01) : (rnd & 8'hFE));
        end else begin
            host.idle();
        end
    endtask

    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        @(negedge clk);
        addr    = a;
        wr_en   = 1'b0;
        valid   = 1'b1;
        rd_mark = 1'b1;
        exp_q.push_back(e);
        @(negedge clk);
        valid   = 1'b0;
        rd_mark = 1'b0;
        addr    = ~a;
    endtask

    // one source case for one cycle, then the hold length and the captured status
    task automatic run(input int k, input logic [8:0] e);
        int n;
        @(negedge clk);
        apply(k);
        @(negedge clk);
        apply(99);
        check(8'(mcu_rst), 8'(e[8]));
        n = 0;
        while (mcu_rst === 1'b1 && n < 50) begin
            @(negedge clk);
            n++;
        end
        if (e[8]) begin
            check(8'(n >= 10 && n < 50), 8'h01);
            rd(16'h1800, e[7:0]);
        end
        $display("test %0d done", k);
    endtask

    task automatic conclude();
        $display("comparisons %0d, mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // ----------------------------------------------------------------
    // read results come off the queue the cycle after each read
    // ----------------------------------------------------------------
    always @(posedge clk) rd_seen <= rd_mark;

    always @(negedge clk) begin
        if (rd_seen) begin
            check(rdata, exp_q.pop_front());
        end
    end

    // ----------------------------------------------------------------
    // main sequence and hang guard
    // ----------------------------------------------------------------
    initial begin
        int n;
        apply(99);
        repeat (12) @(negedge clk);
        check(8'(mcu_rst), 8'h01);
        rst = 1'b0;
        n = 0;
        while (mcu_rst !== 1'b0 && n < 50) begin
            @(negedge clk);
            n++;
        end
        rd(16'h1800, 8'h82);
        rd(16'h1801, 8'h00);
        rd(16'h1802, 8'h00);
        // service write with random data: clear pulse, flags untouched
        @(negedge clk);
        addr  = 16'h1800;
        wdata = 8'($random(seed));
        wr_en = 1'b1;
        valid = 1'b1;
        @(negedge clk);
        valid = 1'b0;
        check(8'(wd_clr), 8'h01);
        @(negedge clk);
        check(8'(wd_clr), 8'h00);
        rd(16'h1800, 8'h82);
        run(19, 9'h182);
        for (int k = 0; k < 22; k++) begin
            run(k, expt[k]);
        end
        conclude();
    end

    // generous against roughly 260 cycles (about 1.3 us) of expected run time
    initial begin
        #60000;
        n_errors++;
        conclude();
    end
endmodule
